// *** rtl/pogc_regs.svh ***
// Register indices, field positions, reset values and timing counts
// for the pixel offset and gain correction block.
// Assumes the includer maps each register index to byte address index*4.
`ifndef POGC_REGS_SVH
`define POGC_REGS_SVH

// Register indices; the byte address is four times the index.
`define POGC_IDX_W 10
`define POGC_IDX_RSVD_FIRST 10'h05B
`define POGC_IDX_CODE_HIGH 10'h05C
`define POGC_IDX_CODE_LOW 10'h05D
`define POGC_IDX_TEST_CTRL 10'h05E
`define POGC_IDX_RSVD_LAST 10'h07F
`define POGC_IDX_CONFIG 10'h010
`define POGC_IDX_STATUS 10'h011

// Field positions.
`define POGC_TEST_SEL_BIT 5
`define POGC_TEST_STROBE_BIT 7
`define POGC_CFG_SPLIT_BIT 0
`define POGC_STAT_BUSY_BIT 16

// Reset values.
`define POGC_TEST_CTRL_RST 8'h00
`define POGC_CODE_HIGH_RST 4'h0
`define POGC_CODE_LOW_RST 8'h00
`define POGC_SPLIT_RST 1'b0

// Datapath limits and bus answers.
`define POGC_SAT_MAX 10'h3FF
`define POGC_RESP_OKAY 2'b00
`define POGC_RESP_DECERR 2'b11

// Timing: clock period, top pixel rate and cycles per pixel (rounded down).
`define POGC_CLK_NS 25
`define POGC_PIX_MHZ 6
`define POGC_PIX_CYC ((1000 / `POGC_PIX_MHZ) / `POGC_CLK_NS)

`endif

// *** rtl/pogc_pkg.sv ***
// Types of the pixel offset and gain correction block.
// Assumes nothing beyond a SystemVerilog compiler.
package pogc_pkg;

    // Pixel sequence, Gray coded along its only path except the return from ST_CALC to ST_IDLE.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH_LO = 3'b001,
        ST_WAIT = 3'b011,
        ST_TAKE_HI = 3'b010,
        ST_TAKE_LO = 3'b110,
        ST_CALC = 3'b111
    } pogc_state_t;

    // Corrected pixel towards the next stage.
    typedef struct packed {
        logic valid;
        logic [9:0] data;
    } pogc_pix_t;

    // Coefficient memory read port.
    typedef struct packed {
        logic [17:0] addr;
        logic oe_n;
    } pogc_sram_t;

    // All state of the core.
    typedef struct packed {
        pogc_state_t state;
        logic [11:0] adc_s1;
        logic [11:0] adc_s2;
        logic stb_s1;
        logic stb_s2;
        logic stb_d;
        logic line_s1;
        logic line_s2;
        logic line_d;
        logic [7:0] dat_s1;
        logic [7:0] dat_s2;
        logic [16:0] pix_idx;
        logic [9:0] code10;
        logic [7:0] off;
        logic [9:0] gain;
        logic [7:0] coef_hi;
        pogc_sram_t sram;
        pogc_pix_t pix;
        logic test_pin;
        logic [3:0] code_high;
        logic [7:0] code_low;
        logic [7:0] test_ctrl;
        logic split8;
        logic aw_held;
        logic [11:0] awaddr;
        logic awready;
        logic w_held;
        logic [7:0] wdata;
        logic wlane0;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pogc_st_t;

endpackage

// *** rtl/pogc_core.sv ***
// Pixel offset and gain correction core with its AXI4-Lite register slave.
// Assumes the converter code, sample strobe, line start and memory data
// arrive from pins, and a zero-wait asynchronous coefficient memory.
//
// What this block does
// - Two coefficient bytes per pixel, split 6/10 or, by config bit, 8/8.
// - Subtract offset from converter code bits 11..2; bits 1..0 unused.
// - Offset larger than code gives zero, never a wrapped value.
// - Both coefficient bytes are read from memory for every pixel.
// - Subtractor result is multiplied by the 10-bit or 8-bit gain.
// - An 8-bit gain forms the top of a 10-bit gain, low bits zero.
// - Products above 1023 are replaced by 1023.
// - One 12-bit sample per pixel is handled at up to 6 MHz.
// - Forced code: high register low nibble on top, low register below.
// - Test bit 5 picks live code (0) or forced code (1).
// - Test bit 7 drives the sample strobe onto the test pin.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps

`include "pogc_regs.svh"

module pogc_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [11:0] adc_code,
    input wire logic sample_strobe,
    input wire logic line_start,
    input wire logic [7:0] sram_data,
    output pogc_pkg::pogc_sram_t sram,
    output pogc_pkg::pogc_pix_t pix_out,
    output logic test_pin
);

    localparam int PIX_CYC = `POGC_PIX_CYC;

    pogc_pkg::pogc_st_t st;
    pogc_pkg::pogc_st_t nx;
    logic accept;
    logic [11:0] sel_code;
    logic [9:0] diff;
    logic [19:0] product;
    logic [15:0] word;

    ////////////////////////////////////////////////////////////////////////
    // Datapath terms shared by the sequencer and the checks.
    always_comb begin
        accept = (st.state == pogc_pkg::ST_IDLE) && st.stb_s2 && !st.stb_d;
        sel_code = st.test_ctrl[`POGC_TEST_SEL_BIT] ?
            {st.code_high, st.code_low} : st.adc_s2;
        diff = (st.code10 > {2'b00, st.off}) ?
            st.code10 - {2'b00, st.off} : 10'h000;
        product = diff * st.gain;
        word = {st.coef_hi, st.dat_s2};
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: synchronisers, pixel sequence and register slave.
    // The pixel sequence takes six cycles, so a 40 MHz clock keeps up with
    // a 6 MHz pixel rate; strobes closer than that are not queued.
    always_comb begin
        nx = st;
        // The converter code passes the same two flops as the strobe, so the code
        // taken at the strobe edge is the one the source held beside it. A source
        // that changes the code within two clocks of its strobe edge is not supported.
        nx.adc_s1 = adc_code;
        nx.adc_s2 = st.adc_s1;
        nx.stb_s1 = sample_strobe;
        nx.stb_s2 = st.stb_s1;
        nx.stb_d = st.stb_s2;
        nx.line_s1 = line_start;
        nx.line_s2 = st.line_s1;
        nx.line_d = st.line_s2;
        nx.dat_s1 = sram_data;
        nx.dat_s2 = st.dat_s1;
        nx.pix.valid = 1'b0;
        nx.test_pin = st.test_ctrl[`POGC_TEST_STROBE_BIT] && st.stb_s2;

        case (st.state)
            pogc_pkg::ST_IDLE: begin
                if (accept) begin
                    nx.code10 = sel_code[11:2];
                    nx.sram.addr = {st.pix_idx, 1'b0};
                    nx.sram.oe_n = 1'b0;
                    nx.state = pogc_pkg::ST_FETCH_LO;
                end
            end
            pogc_pkg::ST_FETCH_LO: begin
                nx.sram.addr = {st.pix_idx, 1'b1};
                nx.state = pogc_pkg::ST_WAIT;
            end
            pogc_pkg::ST_WAIT: begin
                nx.state = pogc_pkg::ST_TAKE_HI;
            end
            pogc_pkg::ST_TAKE_HI: begin
                nx.coef_hi = st.dat_s2;
                nx.state = pogc_pkg::ST_TAKE_LO;
            end
            pogc_pkg::ST_TAKE_LO: begin
                nx.sram.oe_n = 1'b1;
                if (st.split8) begin
                    nx.off = word[15:8];
                    nx.gain = {word[7:0], 2'b00};
                end else begin
                    nx.off = {2'b00, word[15:10]};
                    nx.gain = word[9:0];
                end
                nx.state = pogc_pkg::ST_CALC;
            end
            pogc_pkg::ST_CALC: begin
                nx.pix.valid = 1'b1;
                nx.pix.data = (product > {10'h000, `POGC_SAT_MAX}) ?
                    `POGC_SAT_MAX : product[9:0];
                nx.pix_idx = st.pix_idx + 17'h00001;
                nx.state = pogc_pkg::ST_IDLE;
            end
            default: begin
                nx.state = pogc_pkg::ST_IDLE;
            end
        endcase

        // A new line restarts the coefficient walk at pixel zero.
        if (st.line_s2 && !st.line_d) begin
            nx.pix_idx = 17'h00000;
        end

        // Write address and data are taken independently, then committed.
        nx.awready = awvalid && !st.aw_held && !st.awready && !st.bvalid;
        if (awvalid && st.awready) begin
            nx.aw_held = 1'b1;
            nx.awaddr = awaddr;
        end
        nx.wready = wvalid && !st.w_held && !st.wready && !st.bvalid;
        if (wvalid && st.wready) begin
            nx.w_held = 1'b1;
            nx.wdata = wdata[7:0];
            nx.wlane0 = wstrb[0];
        end
        if (st.bvalid && bready) begin
            nx.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            nx.aw_held = 1'b0;
            nx.w_held = 1'b0;
            nx.bvalid = 1'b1;
            nx.bresp = wr_resp(st.awaddr[11:2]);
            if (st.wlane0) begin
                case (st.awaddr[11:2])
                    `POGC_IDX_CODE_HIGH: nx.code_high = st.wdata[3:0];
                    `POGC_IDX_CODE_LOW: nx.code_low = st.wdata;
                    `POGC_IDX_TEST_CTRL: nx.test_ctrl = st.wdata;
                    `POGC_IDX_CONFIG: nx.split8 = st.wdata[`POGC_CFG_SPLIT_BIT];
                    default: begin
                    end
                endcase
            end
        end

        // Reads answer one cycle after the address is taken.
        nx.arready = arvalid && !st.arready && !st.rvalid;
        if (st.rvalid && rready) begin
            nx.rvalid = 1'b0;
        end
        if (arvalid && st.arready) begin
            nx.rvalid = 1'b1;
            nx.rresp = wr_resp(araddr[11:2]);
            nx.rdata = rd_word(araddr[11:2]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register map helpers. Reserved test registers read zero and take
    // writes without effect, so software that clears them sees OKAY.
    function automatic logic [1:0] wr_resp(input logic [`POGC_IDX_W-1:0] idx);
        logic hit;
        hit = (idx >= `POGC_IDX_RSVD_FIRST && idx <= `POGC_IDX_RSVD_LAST) ||
            idx == `POGC_IDX_CONFIG || idx == `POGC_IDX_STATUS;
        return hit ? `POGC_RESP_OKAY : `POGC_RESP_DECERR;
    endfunction

    function automatic logic [31:0] rd_word(input logic [`POGC_IDX_W-1:0] idx);
        logic [31:0] val;
        val = 32'h00000000;
        case (idx)
            `POGC_IDX_CODE_HIGH: val[3:0] = st.code_high;
            `POGC_IDX_CODE_LOW: val[7:0] = st.code_low;
            `POGC_IDX_TEST_CTRL: val[7:0] = st.test_ctrl;
            `POGC_IDX_CONFIG: val[`POGC_CFG_SPLIT_BIT] = st.split8;
            `POGC_IDX_STATUS: begin
                val[9:0] = st.pix.data;
                val[`POGC_STAT_BUSY_BIT] = (st.state != pogc_pkg::ST_IDLE);
            end
            default: val = 32'h00000000;
        endcase
        return val;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State register; reset only loads constants.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.state <= pogc_pkg::ST_IDLE;
            st.sram.oe_n <= 1'b1;
            st.test_ctrl <= `POGC_TEST_CTRL_RST;
            st.code_high <= `POGC_CODE_HIGH_RST;
            st.code_low <= `POGC_CODE_LOW_RST;
            st.split8 <= `POGC_SPLIT_RST;
        end else begin
            st <= nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs come straight from the state register.
    assign awready = st.awready;
    assign wready = st.wready;
    assign bresp = st.bresp;
    assign bvalid = st.bvalid;
    assign arready = st.arready;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign rvalid = st.rvalid;
    assign sram = st.sram;
    assign pix_out = st.pix;
    assign test_pin = st.test_pin;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the datapath and sequencing.
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    split_offset_a: assert property (
        st.state == pogc_pkg::ST_CALC && !st.split8 |-> st.off[7:6] == 2'b00)
        else $error("offset wider than six bits in 6/10 split");
    code_align_a: assert property (
        accept |=> st.code10 == $past(sel_code[11:2]))
        else $error("subtractor input not taken from code bits 11..2");
    sub_clamp_a: assert property (
        st.state == pogc_pkg::ST_CALC && {2'b00, st.off} >= st.code10
        |=> pix_out.valid && pix_out.data == 10'h000)
        else $error("subtractor did not clamp to zero");
    coef_fetch_a: assert property (
        accept |=> !sram.oe_n && sram.addr == {$past(st.pix_idx), 1'b0}
        ##1 sram.addr[0] == 1'b1)
        else $error("coefficient bytes not fetched for the pixel");
    gain_mult_a: assert property (
        st.state == pogc_pkg::ST_CALC && product <= 20'h003FF
        |=> pix_out.data == $past(product[9:0]))
        else $error("pixel is not offset result times gain");
    gain_pad_a: assert property (
        st.state == pogc_pkg::ST_CALC && st.split8 |-> st.gain[1:0] == 2'b00)
        else $error("8-bit gain not padded with zero low bits");
    mult_sat_a: assert property (
        st.state == pogc_pkg::ST_CALC && product > 20'h003FF
        |=> pix_out.data == 10'h3FF)
        else $error("multiplier did not saturate at 1023");
    pixel_rate_a: assert property (
        accept |-> ##PIX_CYC st.state == pogc_pkg::ST_IDLE)
        else $error("pixel sequence slower than the pixel period");
    forced_code_a: assert property (
        accept && st.test_ctrl[5] |=> st.code10 == $past({st.code_high, st.code_low[7:2]}))
        else $error("forced code not used in test mode");
    strobe_pin_a: assert property (
        ##3 test_pin == ($past(st.test_ctrl[7]) && $past(sample_strobe, 3)))
        else $error("test pin does not follow the sample strobe pin");
    pixel_once_a: assert property (
        accept |-> ##5 !pix_out.valid ##1 pix_out.valid ##1 !pix_out.valid)
        else $error("corrected pixel not passed once per pixel");

    // A committed write with lane zero set must land in the forced code pair.
    code_high_load_a: assert property (
        st.aw_held && st.w_held && !st.bvalid && st.wlane0 &&
        st.awaddr[11:2] == `POGC_IDX_CODE_HIGH |=> st.code_high == $past(st.wdata[3:0]))
        else $error("forced code high nibble not loaded from the write");
    code_low_load_a: assert property (
        st.aw_held && st.w_held && !st.bvalid && st.wlane0 &&
        st.awaddr[11:2] == `POGC_IDX_CODE_LOW |=> st.code_low == $past(st.wdata))
        else $error("forced code low byte not loaded from the write");

    ////////////////////////////////////////////////////////////////////////
    // Checks on the register bus. A response must clear once taken, or the
    // master would see a second answer for a single request.
    resp_clear_a: assert property (
        bvalid && bready |=> !bvalid)
        else $error("write response stands after it was taken");
    read_answer_a: assert property (
        arvalid && arready && !rvalid |=> rvalid)
        else $error("read address taken without an answer next cycle");

endmodule

// *** tb/pogc_coef_mem.sv ***
// Behavioural coefficient memory at the far side of the core's memory port.
// Assumes the bench loads coef[] for pixel index bits 1..0 while the port is idle.
`timescale 1ns/1ps

module pogc_coef_mem (
    input wire logic aclk,
    input wire pogc_pkg::pogc_sram_t sram,
    output logic [7:0] sram_data
);
    logic [15:0] coef [4];
    logic [7:0] last = 8'h5A;

    ////////////////////////////////////////
    // Asynchronous read, even byte is the high half of the word. A released bus shows
    // the inverse of the last byte, so a sample taken too late cannot pass by luck.
    assign sram_data = sram.oe_n ? ~last : (sram.addr[0] ? coef[sram.addr[2:1]][7:0]
        : coef[sram.addr[2:1]][15:8]);

    // Remember the byte last driven while the read enable was low.
    always @(posedge aclk) begin
        if (!sram.oe_n) begin
            last <= sram_data;
        end
    end
endmodule

// *** tb/pixel_offset_gain_correction_tb.sv ***
// Self-checking bench for the pixel offset and gain correction core.
// Assumes the core's AXI4-Lite slave and a zero-wait coefficient memory model.
`timescale 1ns/1ps
`include "pogc_regs.svh"

module pixel_offset_gain_correction_tb;
    localparam logic [1:0] OK = `POGC_RESP_OKAY;
    localparam logic [1:0] DE = `POGC_RESP_DECERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, test_pin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [11:0] adc_code = 12'h000;
    logic sample_strobe = 1'b0, line_start = 1'b0;
    logic [7:0] sram_data;
    pogc_pkg::pogc_sram_t sram;
    pogc_pkg::pogc_pix_t pix_out;
    int err_total = 0;
    int cmp_count = 0;

    pogc_core dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .adc_code, .sample_strobe, .line_start, .sram_data, .sram,
        .pix_out, .test_pin);
    pogc_coef_mem mem (.aclk, .sram, .sram_data);

    // 40 MHz clock.
    always #12.5 aclk = ~aclk;

    ////////////////////////////////////////
    // Compare, count and report.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    // One AXI write; address and data are released as each is taken.
    task automatic wr(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= {ix, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    // One AXI read; data is only compared on an OKAY answer.
    task automatic rd(input logic [9:0] ix, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= {ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        if (er == OK) chk("rdata", {24'h0, e}, rdata);
    endtask

    // One pixel: code and strobe held until the result appears, then spacing kept.
    task automatic px(input logic [11:0] c, input logic [9:0] e, input logic tp);
        @(posedge aclk);
        adc_code <= c;
        sample_strobe <= 1'b1;
        do @(posedge aclk); while (pix_out.valid !== 1'b1);
        chk("pixel", {22'h0, e}, {22'h0, pix_out.data});
        chk("test pin", {31'h0, tp}, {31'h0, test_pin});
        chk("read enable", 32'h1, {31'h0, sram.oe_n});
        sample_strobe <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    // Restart the pixel index so coefficient slots line up with the next group.
    task automatic new_line;
        @(posedge aclk);
        line_start <= 1'b1;
        repeat (3) @(posedge aclk);
        line_start <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////
    // Main sequence: registers, both coefficient splits, then the test paths.
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(`POGC_IDX_CODE_HIGH, 8'h00, OK);
        rd(`POGC_IDX_TEST_CTRL, 8'h00, OK);
        rd(`POGC_IDX_CONFIG, 8'h00, OK);
        wr(`POGC_IDX_RSVD_FIRST, 8'h00, OK);
        wr(10'h200, 8'hFF, DE);
        rd(10'h200, 8'h00, DE);
        wr(`POGC_IDX_CODE_HIGH, 8'hAB, OK);
        rd(`POGC_IDX_CODE_HIGH, 8'h0B, OK);
        wstrb <= 4'h0;
        wr(`POGC_IDX_CODE_HIGH, 8'h05, OK);
        wstrb <= 4'h1;
        rd(`POGC_IDX_CODE_HIGH, 8'h0B, OK);
        wr(`POGC_IDX_RSVD_LAST, 8'h00, OK);
        $display("register test done");
        mem.coef[0] = {6'd5, 10'd3};
        mem.coef[1] = {6'd63, 10'd1};
        mem.coef[2] = {6'd0, 10'd1023};
        mem.coef[3] = {6'd1, 10'd1};
        new_line;
        px(12'h0A7, 10'd108, 1'b0);
        px(12'h050, 10'd0, 1'b0);
        px(12'hFFC, 10'h3FF, 1'b0);
        px(12'h008, 10'd1, 1'b0);
        $display("split 6/10 test done");
        wr(`POGC_IDX_CONFIG, 8'h01, OK);
        mem.coef[0] = 16'h0503;
        mem.coef[1] = 16'hC801;
        new_line;
        px(12'h0A7, 10'd432, 1'b0);
        px(12'h4B0, 10'd400, 1'b0);
        $display("split 8/8 test done");
        wr(`POGC_IDX_CONFIG, 8'h00, OK);
        mem.coef[0] = {6'd0, 10'd1};
        mem.coef[1] = {6'd0, 10'd1};
        wr(`POGC_IDX_CODE_HIGH, 8'h0A, OK);
        wr(`POGC_IDX_CODE_LOW, 8'h7C, OK);
        wr(`POGC_IDX_TEST_CTRL, 8'hA0, OK);
        rd(`POGC_IDX_TEST_CTRL, 8'hA0, OK);
        new_line;
        px(12'h000, 10'h29F, 1'b1);
        wr(`POGC_IDX_TEST_CTRL, 8'h00, OK);
        px(12'h3F0, 10'h0FC, 1'b0);
        rd(`POGC_IDX_STATUS, 8'hFC, OK);
        $display("test mode test done");
        // A second reset in mid-run must bring the forced code back to zero.
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("read enable after reset", 32'h1, {31'h0, sram.oe_n});
        chk("pixel after reset", 32'h0, {22'h0, pix_out.data});
        rd(`POGC_IDX_CODE_LOW, 8'h00, OK);
        rd(`POGC_IDX_CODE_HIGH, 8'h00, OK);
        $display("reset test done");
        wrap_up;
    end

    // Watchdog well beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        wrap_up;
    end
endmodule
